/* src/mpc_out_stage.sv */
/*
 * Output stage of a six-channel motor PWM: top/bottom duty selection,
 * dead-time insertion, pin override and output polarity, with registers.
 * Assumes the counter supplies period pulses and raw generator levels,
 * and the duty logic consumes the pair selection it is given.
 */
// Summary of operation
// - Methods 00 and 01 select duty values from the software direction bits.
// - Method 10 latches each sense pin while both pair outputs are off.
// - At 0 or 100 percent duty no dead time, so old sense kept.
// - Method 11 latches at mid cycle (center) or cycle end (edge).
// - Top/bottom selection applies only to complementary pairs.
// - At each period start the latched value picks odd or even duty.
// - Direction bits and sense values are buffered to period boundaries.
// - The method field is unbuffered and acts immediately.
// - First period after enable with pin sensing uses duty registers 1,3,5.
// - Top inversion covers channels 1,3,5; bottom covers 2,4,6.
// - Positive polarity drives active high, negative drives active low.
// - Polarity options are write-once.
// - Override makes each pin follow its bit; independent 1 is active.
// - Override complementary: odd bit sets top, even bit allows complement.
// - Polarity still applies under override.
// - Complementary: odd override bits feed dead-time logic; pair never both active.
// - Even bit changes insert no dead time yet never violate it.
// - Override leaves generator and sensing running, only pins detached.
// - Override drives pins even while the module is disabled.
// - After override clears, generator drives pins from next period.
// - Dead time is an 8-bit count of clock cycles.
// - Sense or direction 0 selects odd duty, 1 selects even duty.
`timescale 1ns/1ns
`default_nettype none
module mpc_out_stage
    import mpc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mpc_tick_t tick,
    input wire logic [5:0] gen_pwm,
    input wire logic [2:0] phase_sense_pins,
    output logic [2:0] pair_use_even,
    output logic [5:0] pwm_pin
);
    // Software state
    mpc_ctrl_t ctrl_q;
    logic [2:0] sw_current_dir_bits_q;
    logic [5:0] pin_override_bits_q;
    logic pin_override_enable_q;
    logic top_invert_option_q;
    logic bottom_invert_option_q;
    logic pol_locked_q;
    logic [7:0] dead_time_q;

    // Bus state
    logic aw_held_q, w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic wr_fire;

    // Datapath state
    logic [2:0] sns_meta_q, sns_sync_q;
    logic [2:0] sense_lat_q;
    logic [2:0] sel_q;
    logic first_q;
    logic en_prev_q;
    logic ovr_hold_q;
    logic route_ovr;
    logic [5:0] act;
    logic [5:0] pwm_pin_q;
    logic [5:0] inv_mask;

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response, held until the master accepts it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= MPC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (aw_addr_q[ADDR_W-1:2] > MPC_STAT_OFS[ADDR_W-1:2])
                ? MPC_RESP_SLVERR : MPC_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register writes; only byte lane 0 carries fields
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= '0;
            sw_current_dir_bits_q <= 3'h0;
            pin_override_bits_q <= 6'h00;
            pin_override_enable_q <= 1'b0;
            dead_time_q <= MPC_DT_RST;
        end else if (wr_fire && w_strb_q[0]) begin
            case (aw_addr_q[ADDR_W-1:2])
                MPC_CTRL_OFS[ADDR_W-1:2]: begin
                    // Takes effect at once, mid-period included
                    ctrl_q <= w_data_q[4:0];
                end
                MPC_DIR_OFS[ADDR_W-1:2]: begin
                    sw_current_dir_bits_q <= w_data_q[2:0];
                end
                MPC_OVR_OFS[ADDR_W-1:2]: begin
                    pin_override_bits_q <= w_data_q[5:0];
                    pin_override_enable_q <= w_data_q[MPC_OVR_EN_BIT];
                end
                MPC_DT_OFS[ADDR_W-1:2]: begin
                    dead_time_q <= w_data_q[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Polarity: first write locks it, a guard against gate-drive damage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            top_invert_option_q <= 1'b0;
            bottom_invert_option_q <= 1'b0;
            pol_locked_q <= 1'b0;
        end else if (wr_fire && w_strb_q[0] && !pol_locked_q &&
                aw_addr_q[ADDR_W-1:2] == MPC_POL_OFS[ADDR_W-1:2]) begin
            top_invert_option_q <= w_data_q[MPC_POL_TOP_BIT];
            bottom_invert_option_q <= w_data_q[MPC_POL_BOT_BIT];
            pol_locked_q <= 1'b1;
        end
    end

    // Read channel, one outstanding read
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= MPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= MPC_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            case (s_axi_araddr[ADDR_W-1:2])
                MPC_CTRL_OFS[ADDR_W-1:2]: rdata_q[4:0] <= ctrl_q;
                MPC_DIR_OFS[ADDR_W-1:2]: rdata_q[2:0] <= sw_current_dir_bits_q;
                MPC_OVR_OFS[ADDR_W-1:2]: begin
                    rdata_q[5:0] <= pin_override_bits_q;
                    rdata_q[MPC_OVR_EN_BIT] <= pin_override_enable_q;
                end
                MPC_POL_OFS[ADDR_W-1:2]: begin
                    rdata_q[MPC_POL_TOP_BIT] <= top_invert_option_q;
                    rdata_q[MPC_POL_BOT_BIT] <= bottom_invert_option_q;
                    rdata_q[7] <= pol_locked_q;
                end
                MPC_DT_OFS[ADDR_W-1:2]: rdata_q[7:0] <= dead_time_q;
                MPC_STAT_OFS[ADDR_W-1:2]: begin
                    rdata_q[2:0] <= sel_q;
                    rdata_q[5:3] <= sense_lat_q;
                    rdata_q[6] <= route_ovr;
                    rdata_q[7] <= first_q;
                end
                default: rresp_q <= MPC_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Two-stage sense synchroniser; only the second stage is used
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sns_meta_q <= 3'h0;
            sns_sync_q <= 3'h0;
        end else begin
            sns_meta_q <= phase_sense_pins;
            sns_sync_q <= sns_meta_q;
        end
    end

    // Sense latch; keeps running under override
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sense_lat_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ctrl_q.sense_method_field == MPC_SNS_DEAD &&
                        ctrl_q.module_enable_bit &&
                        !act[2*i] && !act[2*i+1]) begin
                    sense_lat_q[i] <= sns_sync_q[i];
                end else if (ctrl_q.sense_method_field == MPC_SNS_EDGE &&
                        (ctrl_q.center_aligned ? tick.mid_cycle
                                               : tick.cycle_end)) begin
                    sense_lat_q[i] <= sns_sync_q[i];
                end
            end
        end
    end

    // First period after enable has nothing sensed yet
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_prev_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            en_prev_q <= ctrl_q.module_enable_bit;
            if (ctrl_q.module_enable_bit && !en_prev_q) begin
                first_q <= 1'b1;
            end else if (tick.period_start) begin
                first_q <= 1'b0;
            end
        end
    end

    // Selection buffered to the period start; 0 picks odd, 1 even
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= MPC_SEL_RST;
        end else if (tick.period_start) begin
            if (!ctrl_q.sense_method_field[1]) begin
                sel_q <= sw_current_dir_bits_q;
            end else if (first_q) begin
                sel_q <= 3'h0;
            end else begin
                sel_q <= sense_lat_q;
            end
        end
    end

    // Independent channels keep their own duty registers
    assign pair_use_even = ctrl_q.independent_channels_option
        ? 3'h0 : sel_q;

    // Override holds the pins until the next period after release
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_hold_q <= 1'b0;
        end else if (pin_override_enable_q) begin
            ovr_hold_q <= 1'b1;
        end else if (tick.period_start || !ctrl_q.module_enable_bit) begin
            ovr_hold_q <= 1'b0;
        end
    end
    assign route_ovr = pin_override_enable_q || ovr_hold_q;

    // Per pair: dead-time counter driven by the top input
    for (genvar p = 0; p < 3; p++) begin : g_pair
        logic top_in, top_prev_q, toggle, bot_ok;
        logic [7:0] dt_cnt_q;

        // Odd override bit or generator top feeds dead-time logic
        assign top_in = pin_override_enable_q ? pin_override_bits_q[2*p]
            : (!ovr_hold_q && ctrl_q.module_enable_bit && gen_pwm[2*p]);
        assign bot_ok = pin_override_enable_q ? pin_override_bits_q[2*p+1]
            : (!ovr_hold_q && ctrl_q.module_enable_bit);
        assign toggle = (top_in != top_prev_q) && (dead_time_q != 8'h00);

        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                top_prev_q <= 1'b0;
                dt_cnt_q <= 8'h00;
            end else begin
                top_prev_q <= top_in;
                if (toggle) begin
                    dt_cnt_q <= dead_time_q - 8'h01;
                end else if (dt_cnt_q != 8'h00) begin
                    dt_cnt_q <= dt_cnt_q - 8'h01;
                end
            end
        end

        // Channel activity before polarity
        always_comb begin
            if (ctrl_q.independent_channels_option) begin
                act[2*p] = pin_override_enable_q ? pin_override_bits_q[2*p]
                    : (bot_ok && gen_pwm[2*p]);
                act[2*p+1] = pin_override_enable_q
                    ? pin_override_bits_q[2*p+1]
                    : (bot_ok && gen_pwm[2*p+1]);
            end else begin
                act[2*p] = top_in && !toggle && dt_cnt_q == 8'h00;
                // Even bit only gates; top must be off, so no overlap
                act[2*p+1] = bot_ok && !top_in && !toggle &&
                    dt_cnt_q == 8'h00;
            end
        end

        // Pair never active together in complementary use
        property p_no_overlap;
            @(posedge sys_clk) disable iff (!arst_n)
            !ctrl_q.independent_channels_option |-> !(act[2*p] && act[2*p+1]);
        endproperty
        a_no_overlap: assert property (p_no_overlap)
            else $error("pair outputs active together");

        // A top edge forces both off for the whole dead time
        property p_dead_gap;
            @(posedge sys_clk) disable iff (!arst_n)
            (!ctrl_q.independent_channels_option && dead_time_q == 8'h03 &&
             top_in != top_prev_q) |-> (!act[2*p] && !act[2*p+1])[*3];
        endproperty
        a_dead_gap: assert property (p_dead_gap)
            else $error("dead time cut short");

        // Dead-time method only captures while both are off
        property p_sense_dead;
            @(posedge sys_clk) disable iff (!arst_n)
            (ctrl_q.sense_method_field == MPC_SNS_DEAD &&
             (act[2*p] || act[2*p+1])) |=> $stable(sense_lat_q[p]);
        endproperty
        a_sense_dead: assert property (p_sense_dead)
            else $error("sense captured outside dead time");
    end

    // Polarity inversion mask: even index top, odd index bottom
    assign inv_mask = {3{bottom_invert_option_q, top_invert_option_q}};

    // Registered pins; polarity applies in every mode
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_pin_q <= 6'h00;
        end else begin
            pwm_pin_q <= act ^ inv_mask;
        end
    end
    assign pwm_pin = pwm_pin_q;

    // Selection changes only on a period start
    property p_sel_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        !tick.period_start |=> $stable(sel_q);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("selection changed mid period");

    // Software method copies direction bits at period start
    property p_sw_sel;
        @(posedge sys_clk) disable iff (!arst_n)
        (tick.period_start && !ctrl_q.sense_method_field[1])
            |=> sel_q == $past(sw_current_dir_bits_q);
    endproperty
    a_sw_sel: assert property (p_sw_sel)
        else $error("software direction not applied");

    // Enable rise then period start with sensing gives odd registers
    sequence s_enable_rise;
        !ctrl_q.module_enable_bit ##1 ctrl_q.module_enable_bit;
    endsequence
    property p_first_period;
        @(posedge sys_clk) disable iff (!arst_n)
        s_enable_rise ##1 (tick.period_start &&
            ctrl_q.sense_method_field[1]) |=> sel_q == 3'h0;
    endproperty
    a_first_period: assert property (p_first_period)
        else $error("first period not using odd registers");

    // Pins follow activity with one register of polarity
    property p_polarity;
        @(posedge sys_clk) disable iff (!arst_n)
        pol_locked_q |=> pwm_pin == ($past(act) ^
            {3{bottom_invert_option_q, top_invert_option_q}});
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("pin polarity wrong");

    // Once locked, polarity never changes
    property p_write_once;
        @(posedge sys_clk) disable iff (!arst_n)
        pol_locked_q |=> $stable({top_invert_option_q,
            bottom_invert_option_q});
    endproperty
    a_write_once: assert property (p_write_once)
        else $error("polarity changed after lock");

    // Independent override follows the bits even when disabled
    property p_ovr_independent_channels_option;
        @(posedge sys_clk) disable iff (!arst_n)
        (pin_override_enable_q && ctrl_q.independent_channels_option)
            |-> act == pin_override_bits_q;
    endproperty
    a_ovr_independent_channels_option: assert property (p_ovr_independent_channels_option)
        else $error("override bits not on channels");

    // Release of override waits for the period start
    sequence s_ovr_release;
        pin_override_enable_q ##1 !pin_override_enable_q &&
            !tick.period_start && ctrl_q.module_enable_bit;
    endsequence
    property p_ovr_release;
        @(posedge sys_clk) disable iff (!arst_n)
        s_ovr_release |-> route_ovr;
    endproperty
    a_ovr_release: assert property (p_ovr_release)
        else $error("generator resumed before period start");

    // Mid-cycle capture in center-aligned edge method
    property p_sense_mid;
        @(posedge sys_clk) disable iff (!arst_n)
        (ctrl_q.sense_method_field == MPC_SNS_EDGE && ctrl_q.center_aligned
            && tick.mid_cycle) |=> sense_lat_q == $past(sns_sync_q);
    endproperty
    a_sense_mid: assert property (p_sense_mid)
        else $error("mid-cycle sense not captured");

    // Write response stands until accepted
    property p_bresp_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped");
endmodule
`default_nettype wire

/* src/mpc_pkg.sv */
/*
 * Shared constants and types for the motor PWM correction and output stage.
 * Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
 */
`default_nettype none
package mpc_pkg;
    // Register byte offsets
    localparam logic [7:0] MPC_CTRL_OFS = 8'h00;
    localparam logic [7:0] MPC_DIR_OFS = 8'h04;
    localparam logic [7:0] MPC_OVR_OFS = 8'h08;
    localparam logic [7:0] MPC_POL_OFS = 8'h0C;
    localparam logic [7:0] MPC_DT_OFS = 8'h10;
    localparam logic [7:0] MPC_STAT_OFS = 8'h14;

    // Control register field positions
    localparam int MPC_CTRL_EN_BIT = 0;
    localparam int MPC_CTRL_INDEPENDENT_CHANNELS_OPTION_BIT = 1;
    localparam int MPC_CTRL_CENTER_BIT = 2;
    localparam int MPC_CTRL_SENSE_LSB = 3;
    // Override register: six pin bits low, enable at the top
    localparam int MPC_OVR_EN_BIT = 7;
    // Polarity register: top and bottom inversion
    localparam int MPC_POL_TOP_BIT = 0;
    localparam int MPC_POL_BOT_BIT = 1;

    // Reset values
    localparam logic [7:0] MPC_DT_RST = 8'h00;
    localparam logic [2:0] MPC_SEL_RST = 3'h0;

    // AXI responses
    localparam logic [1:0] MPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MPC_RESP_SLVERR = 2'h2;

    // Correction method codes
    typedef enum logic [1:0] {
        MPC_SNS_SW0 = 2'h0,
        MPC_SNS_SW1 = 2'h1,
        MPC_SNS_DEAD = 2'h2,
        MPC_SNS_EDGE = 2'h3
    } mpc_sense_t;

    // Control bits that steer the block
    typedef struct packed {
        mpc_sense_t sense_method_field;
        logic center_aligned;
        logic independent_channels_option;
        logic module_enable_bit;
    } mpc_ctrl_t;

    // Period timing pulses from the counter
    typedef struct packed {
        logic period_start;
        logic mid_cycle;
        logic cycle_end;
    } mpc_tick_t;
endpackage
`default_nettype wire

/* verif/mpc_phase_model.sv */
/*
 * Phase current-sense model: drives the three sense pins.
 * Assumes the bench commands the current direction of each phase.
 */
`timescale 1ns/1ns
`default_nettype none
module mpc_phase_model (
    input wire logic sys_clk,
    input wire logic [2:0] cur_neg,
    output logic [2:0] phase_sense_pins
);
    // Pin high on negative current; comparator lags one clock
    always_ff @(posedge sys_clk) begin
        phase_sense_pins <= cur_neg;
    end
endmodule
`default_nettype wire

/* verif/mpc_bench.sv */
/*
 * Self-checking bench for the PWM correction and output stage.
 * Assumes the bench plays counter, generator and AXI4-Lite master.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module motor_pwm_correction_and_output_control_bench;
    import mpc_pkg::*;
    logic sys_clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, b;
    logic [2:0] cur_neg, sense, use_even;
    logic [5:0] gen, pins;
    mpc_tick_t tick;
    int error_cnt = 0;
    int tests_run = 0;
    localparam mpc_tick_t PER = 3'b100;
    localparam mpc_tick_t MID = 3'b010;
    localparam mpc_tick_t ENDC = 3'b001;

    mpc_out_stage dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tick(tick), .gen_pwm(gen),
        .phase_sense_pins(sense), .pair_use_even(use_even), .pwm_pin(pins));
    mpc_phase_model phase_u (.sys_clk(sys_clk), .cur_neg(cur_neg),
        .phase_sense_pins(sense));

    // Free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge sys_clk); while (!bvalid);
        b = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // One-cycle counter pulse, then let the selection land
    task automatic tk(input mpc_tick_t t);
        @(posedge sys_clk);
        tick <= t;
        @(posedge sys_clk);
        tick <= '0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic t_regs();
        rd(MPC_DT_OFS);
        `CHK("dt", 32'h0, d)
        rd(8'h20);
        `CHK("rresp", MPC_RESP_SLVERR, r)
        wr(MPC_POL_OFS, 32'h1);
        `CHK("bresp ok", MPC_RESP_OKAY, b)
        wr(8'h20, 32'h0);
        `CHK("bresp err", MPC_RESP_SLVERR, b)
        wr(MPC_POL_OFS, 32'h2);
        rd(MPC_POL_OFS);
        `CHK("pol", 32'h81, d)
        #1;
        `CHK("idle pins", 6'h15, pins)
    endtask

    task automatic t_dir();
        wr(MPC_CTRL_OFS, 32'h09);
        wr(MPC_DIR_OFS, 32'h5);
        `CHK("held sel", 3'h0, use_even)
        tk(PER);
        `CHK("dir sel", 3'h5, use_even)
        wr(MPC_CTRL_OFS, 32'h0B);
        `CHK("independent_channels_option sel", 3'h0, use_even)
        wr(MPC_CTRL_OFS, 32'h01);
        wr(MPC_DIR_OFS, 32'h2);
        tk(PER);
        `CHK("dir00 sel", 3'h2, use_even)
    endtask

    task automatic t_sense();
        wr(MPC_CTRL_OFS, 32'h0);
        cur_neg <= 3'h7;
        wr(MPC_CTRL_OFS, 32'h19);
        tk(PER);
        `CHK("first sel", 3'h0, use_even)
        tk(ENDC);
        tk(PER);
        `CHK("end sel", 3'h7, use_even)
        cur_neg <= 3'h2;
        tk(MID);
        tk(PER);
        `CHK("mid ignored", 3'h7, use_even)
        tk(ENDC);
        tk(PER);
        `CHK("end sel2", 3'h2, use_even)
        // Center aligned: cycle end ignored, mid cycle captures
        cur_neg <= 3'h4;
        wr(MPC_CTRL_OFS, 32'h1D);
        tk(ENDC);
        tk(PER);
        `CHK("center end", 3'h2, use_even)
        tk(MID);
        tk(PER);
        `CHK("center mid", 3'h4, use_even)
        // Dead-time sensing needs a top toggle to open a gap
        wr(MPC_DT_OFS, 32'h3);
        gen <= 6'h15;
        cur_neg <= 3'h5;
        wr(MPC_CTRL_OFS, 32'h11);
        repeat (4) @(posedge sys_clk);
        gen <= 6'h00;
        repeat (6) @(posedge sys_clk);
        tk(PER);
        `CHK("gap sel", 3'h5, use_even)
        cur_neg <= 3'h2;
        repeat (8) @(posedge sys_clk);
        tk(PER);
        `CHK("no gap sel", 3'h5, use_even)
        // Re-enable with a nonzero latch; period starts next cycle
        wr(MPC_CTRL_OFS, 32'h10);
        wr(MPC_CTRL_OFS, 32'h11);
        tick <= PER;
        @(posedge sys_clk);
        tick <= '0;
        @(posedge sys_clk);
        #1;
        `CHK("first sel2", 3'h0, use_even)
    endtask

    task automatic t_ovr();
        wr(MPC_CTRL_OFS, 32'h0);
        wr(MPC_OVR_OFS, 32'h80);
        wr(MPC_OVR_OFS, 32'h81);
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("ovr top", 6'h14, pins)
        wr(MPC_OVR_OFS, 32'h83);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("ovr even", 6'h14, pins)
        wr(MPC_OVR_OFS, 32'h82);
        #1;
        `CHK("ovr gap", 6'h15, pins)
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("ovr bot", 6'h17, pins)
        wr(MPC_OVR_OFS, 32'h80);
        wr(MPC_CTRL_OFS, 32'h02);
        wr(MPC_OVR_OFS, 32'hBF);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("ovr independent_channels_option", 6'h2A, pins)
        wr(MPC_OVR_OFS, 32'h80);
        // Release with the module running: generator waits for a period
        gen <= 6'h3F;
        wr(MPC_CTRL_OFS, 32'h03);
        wr(MPC_OVR_OFS, 32'h0);
        #1;
        `CHK("ovr held", 6'h15, pins)
        tk(PER);
        `CHK("gen resumed", 6'h2A, pins)
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, cur_neg, gen, tick} = '0;
        wstrb = 4'hF;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_dir();
        t_sense();
        t_ovr();
        finish_test();
    end

    // Watchdog against a stuck handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
